// File: design/divide_step_pkg.sv
// Purpose: shared types and constants for the divide step unit
// Assumes: one 20 MHz core clock, asynchronous active-high reset
// Notes: a step's result is written back one clock after issue
package divide_step_pkg;

  localparam int unsigned DVD_W = 32;
  localparam int unsigned DVS_W = 16;
  localparam int unsigned HALF_W = 16;
  localparam int unsigned DVD_MSB = 31;
  localparam int unsigned DVS_MSB = 15;
  localparam int unsigned UPPER_LSB = 16;
  localparam int unsigned STEP_CNT_W = 5;
  localparam int unsigned SIGNED_STEPS = 15;
  localparam int unsigned UNSIGNED_STEPS = 16;

  localparam logic [DVD_W-1:0] DVD_RESET = 32'h0000_0000;
  localparam logic [HALF_W-1:0] HALF_ZERO = 16'h0000;
  localparam logic [STEP_CNT_W-1:0] STEP_CNT_RESET = 5'h00;
  localparam logic [STEP_CNT_W-1:0] STEP_CNT_ONE = 5'h01;
  localparam logic [STEP_CNT_W-1:0] STEP_CNT_MAX = 5'h1F;
  localparam logic FLAG_RESET = 1'b0;

  typedef enum logic {
    OP_SIGN_INIT,
    OP_QUOTIENT_STEP
  } step_op_t;

  // one issue slot as the sequencer presents it
  typedef struct packed {
    logic valid;
    step_op_t op;
    logic paired;
  } step_req_t;

  // software access to the two status flags this unit owns
  typedef struct packed {
    logic aq_wr;
    logic aq_wdata;
    logic ov_clr;
  } flag_wr_t;

endpackage : divide_step_pkg

// File: design/divide_primitive_step_unit.sv
// Purpose: sign-initialisation and quotient steps of a non-restoring
//   add/subtract division, one quotient bit per issued step
// Assumes: the sequencer presents the current dividend register value
//   (forwarded if the previous step just wrote it) with each step
// Notes: the dividend register itself lives in the register file; this
//   unit returns the new value with a write strobe
// Contract
// RL1: dividend full 32 bits, divisor low 16
// RL2: software chooses signed or unsigned start
// RL3: 1+15 signed steps, 16 unsigned steps
// RL4: fewer steps give fewer quotient bits
// RL5: result written to dividend, divisor untouched
// RL6: quotient ends in dividend low half
// RL7: sign step sets flag, no add
// RL8: flag 1 adds, flag 0 subtracts
// RL9: both steps shift dividend left once
// RL10: flag is dividend MSB xor divisor MSB
// RL11: overflow sets accumulator overflow flag
// RL12: overflow on zero or small divisor
// RL13: software derives quotient format
// RL14: fractional upper half below divisor magnitude
// RL15: integer dividends pre-shifted into 31.1
// RL16: negative divisor gives quotient one low
// RL17: unsigned divisor at most 0x7FFF
// RL18: divide steps never share issue slot
// RL19: sign step shifts new flag into LSB
// RL20: quotient step shifts inverted flag into LSB
// RL21: add or subtract acts on upper half
`timescale 1ns/10ps

module divide_primitive_step_unit
  import divide_step_pkg::*;
#(
  parameter int unsigned DIVIDEND_W = DVD_W,
  parameter int unsigned DIVISOR_W = DVS_W
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire step_req_t i_step,
  input wire logic [DIVIDEND_W-1:0] i_dividend,
  input wire logic [DIVIDEND_W-1:0] i_divisor_reg,
  input wire flag_wr_t i_flag_wr,
  output logic [DIVIDEND_W-1:0] o_dividend,
  output logic o_dividend_wr,
  output logic o_quotient_sign_flag,
  output logic o_accumulator_overflow_flag,
  output logic o_overflow_event,
  output logic o_pair_refused,
  output logic o_signed_mode,
  output logic [STEP_CNT_W-1:0] o_steps_done
);

  // magnitude of a 16-bit value, signed or plain
  function automatic logic [HALF_W-1:0] magnitude(
    input logic [HALF_W-1:0] value,
    input logic is_signed
  );
    logic [HALF_W-1:0] neg;
    neg = HALF_ZERO - value;
    magnitude = (is_signed && value[HALF_W-1]) ? neg : value;
  endfunction : magnitude

  logic [DIVIDEND_W-1:0] dividend_q;
  logic [DIVIDEND_W-1:0] dividend_d;
  logic dividend_wr_q;
  logic aq_q;
  logic aq_d;
  logic ov_q;
  logic ov_d;
  logic ov_event_q;
  logic pair_refused_q;
  logic signed_q;
  logic signed_d;
  logic [STEP_CNT_W-1:0] steps_q;
  logic [STEP_CNT_W-1:0] steps_d;

  // a divide step is only ever taken when it has the slot to itself
  wire logic step_taken = i_step.valid && !i_step.paired; // RL18
  wire logic step_refused = i_step.valid && i_step.paired; // RL18
  wire logic is_sign_init = step_taken && (i_step.op == OP_SIGN_INIT);
  wire logic is_quot_step = step_taken &&
    (i_step.op == OP_QUOTIENT_STEP);

  // upper half of the divisor register is never looked at
  wire logic [HALF_W-1:0] divisor = i_divisor_reg[DVS_W-1:0]; // RL1
  wire logic [HALF_W-1:0] upper = i_dividend[DVD_MSB:UPPER_LSB]; // RL1
  wire logic [HALF_W-1:0] lower = i_dividend[UPPER_LSB-1:0];

  // sign step: flag from operand signs, no arithmetic
  wire logic init_aq = i_dividend[DVD_MSB] ^ divisor[DVS_MSB]; // RL7 RL10
  wire logic [DIVIDEND_W-1:0] init_result =
    {i_dividend[DVD_MSB-1:0], init_aq}; // RL9 RL19

  // quotient step: add when flag set, subtract when clear
  wire logic [HALF_W-1:0] upper_sum = upper + divisor;
  wire logic [HALF_W-1:0] upper_diff = upper - divisor;
  wire logic [HALF_W-1:0] upper_new =
    aq_q ? upper_sum : upper_diff; // RL8 RL21
  wire logic [DIVIDEND_W-1:0] partial = {upper_new, lower}; // RL21
  wire logic quot_aq = partial[DVD_MSB] ^ divisor[DVS_MSB]; // RL8 RL10
  wire logic [DIVIDEND_W-1:0] quot_result =
    {partial[DVD_MSB-1:0], ~quot_aq}; // RL9 RL20 RL6

  // overflow is judged on the operands at a sign step and at any quotient step taken while the step count is zero;
  // later steps see a partial remainder, not the original dividend
  wire logic first_step = is_sign_init ||
    (is_quot_step && (steps_q == STEP_CNT_RESET));
  wire logic mode_signed = is_sign_init || signed_q;
  wire logic [HALF_W-1:0] upper_mag = magnitude(upper, mode_signed);
  wire logic [HALF_W-1:0] divisor_mag = magnitude(divisor, mode_signed);
  wire logic divisor_zero = (divisor == HALF_ZERO); // RL12
  wire logic divisor_small = (divisor_mag <= upper_mag); // RL12
  wire logic overflow_now = first_step &&
    (divisor_zero || divisor_small); // RL12

  // a negative divisor in signed mode is computed as-is; the quotient
  // then comes out one LSB low, which software must correct
  wire logic neg_divisor = divisor[DVS_MSB]; // RL16

  // next dividend value; only the dividend is ever written back
  always_comb begin
    dividend_d = dividend_q;
    if (is_sign_init) begin
      dividend_d = init_result; // RL5
    end else if (is_quot_step) begin
      dividend_d = quot_result; // RL5
    end
  end

  // quotient-sign flag: a step in the same cycle wins over software
  always_comb begin
    aq_d = aq_q;
    if (is_sign_init) begin
      aq_d = init_aq; // RL7
    end else if (is_quot_step) begin
      aq_d = quot_aq; // RL8
    end else if (i_flag_wr.aq_wr) begin
      aq_d = i_flag_wr.aq_wdata; // RL2
    end
  end

  // accumulator overflow: hardware set beats a software clear
  always_comb begin
    ov_d = ov_q;
    if (overflow_now) begin
      ov_d = 1'b1; // RL11
    end else if (i_flag_wr.ov_clr) begin
      ov_d = 1'b0;
    end
  end

  // mode and step count: a sign step opens a signed sequence, a
  // software write of the flag opens an unsigned one
  always_comb begin
    signed_d = signed_q;
    steps_d = steps_q;
    if (is_sign_init) begin
      signed_d = 1'b1; // RL2
      steps_d = STEP_CNT_RESET;
    end else if (is_quot_step) begin
      // stopping early is legal and only leaves fewer quotient bits
      if (steps_q != STEP_CNT_MAX) begin
        steps_d = steps_q + STEP_CNT_ONE; // RL4 RL3
      end
    end else if (i_flag_wr.aq_wr) begin
      signed_d = 1'b0; // RL2
      steps_d = STEP_CNT_RESET;
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      dividend_q <= DVD_RESET;
      dividend_wr_q <= 1'b0;
    end else begin
      dividend_q <= dividend_d;
      dividend_wr_q <= step_taken; // RL5
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      aq_q <= FLAG_RESET;
      ov_q <= FLAG_RESET;
      ov_event_q <= 1'b0;
    end else begin
      aq_q <= aq_d;
      ov_q <= ov_d;
      ov_event_q <= overflow_now; // RL11
    end
  end

  always_ff @(posedge i_clock or posedge i_rst) begin
    if (i_rst) begin
      signed_q <= 1'b0;
      steps_q <= STEP_CNT_RESET;
      pair_refused_q <= 1'b0;
    end else begin
      signed_q <= signed_d;
      steps_q <= steps_d;
      pair_refused_q <= step_refused; // RL18
    end
  end

  assign o_dividend = dividend_q;
  assign o_dividend_wr = dividend_wr_q;
  assign o_quotient_sign_flag = aq_q;
  assign o_accumulator_overflow_flag = ov_q;
  assign o_overflow_event = ov_event_q;
  assign o_pair_refused = pair_refused_q;
  assign o_signed_mode = signed_q;
  assign o_steps_done = steps_q;

endmodule : divide_primitive_step_unit

// File: sim/divide_primitive_step_unit_assertions.sv
// Purpose: port checks for the divide step unit
// Assumes: one clock, asynchronous active-high reset
// Notes: expected step results are rebuilt from the sampled operands
`timescale 1ns/10ps
module divide_step_chk
  import divide_step_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire step_req_t i_step,
  input wire logic [31:0] i_dividend,
  input wire logic [31:0] i_divisor_reg,
  input wire flag_wr_t i_flag_wr,
  input wire logic [31:0] o_dividend,
  input wire logic o_dividend_wr,
  input wire logic o_quotient_sign_flag,
  input wire logic o_accumulator_overflow_flag,
  input wire logic o_overflow_event,
  input wire logic o_pair_refused,
  input wire logic o_signed_mode,
  input wire logic [4:0] o_steps_done
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (i_rst);
  wire tk = i_step.valid && !i_step.paired;
  wire sg = i_step.op == OP_SIGN_INIT;
  wire [15:0] dv = i_divisor_reg[15:0];
  wire [15:0] hi = i_dividend[31:16];
  wire [15:0] u = o_quotient_sign_flag ? hi + dv : hi - dv;
  wire aq = sg ? i_dividend[31] ^ dv[15] : u[15] ^ dv[15];
  wire [31:0] nd = sg ? {i_dividend[30:0], aq} :
    {u[14:0], i_dividend[15:0], ~aq};
  sequence s_sign_q;
    tk && sg ##1 !i_step.valid ##1 tk && !sg;
  endsequence
  chk_step_result:
  assert property (tk |=> o_dividend_wr && o_dividend == $past(nd))
    else $error("step result wrong");
  chk_flag_update:
  assert property (tk |=> o_quotient_sign_flag == $past(aq))
    else $error("sign flag wrong");
  chk_pair_refused:
  assert property (i_step.valid && i_step.paired |=>
    o_pair_refused && !o_dividend_wr) else $error("pair not refused");
  chk_dividend_hold:
  assert property (!tk |=> !o_dividend_wr && $stable(o_dividend))
    else $error("dividend moved");
  chk_sign_opens:
  assert property (tk && sg |=> o_steps_done == 5'h00 && o_signed_mode)
    else $error("sign step start wrong");
  chk_step_count:
  assert property (tk && !sg && o_steps_done != 5'h1F |=>
    o_steps_done == $past(o_steps_done) + 5'h01) else $error("count");
  chk_sign_then_q:
  assert property (s_sign_q |=> o_steps_done == 5'h01)
    else $error("first quotient step count");
  chk_ovf_zero:
  assert property (tk && sg && dv == 16'h0000 |=>
    o_overflow_event && o_accumulator_overflow_flag) else $error("ovf");
  chk_ovf_sticky:
  assert property (o_accumulator_overflow_flag && !i_flag_wr.ov_clr |=>
    o_accumulator_overflow_flag) else $error("overflow flag lost");
endmodule : divide_step_chk

bind divide_primitive_step_unit divide_step_chk chk (.*);

// File: sim/divide_primitive_step_unit_tb.sv
// Purpose: self-checking bench for the divide step unit
// Assumes: bench forwards each result as the next dividend
// Notes: steps are spaced two cycles apart
`timescale 1ns/10ps
`define CHK(n,e,a) begin checks++; if ((a) !== (e)) begin n_errors++; \
  $display("Error %s exp %h got %h", n, e, a); end end
module divide_primitive_step_unit_tb;
  import divide_step_pkg::*;
  logic i_clock, i_rst, o_dividend_wr, o_quotient_sign_flag, aq;
  logic o_accumulator_overflow_flag, o_overflow_event;
  logic o_pair_refused, o_signed_mode;
  logic [4:0] o_steps_done;
  logic [31:0] i_dividend, i_divisor_reg, o_dividend, ex;
  logic [15:0] u;
  step_req_t i_step;
  flag_wr_t i_flag_wr;
  int n_errors = 0;
  int checks = 0;
  divide_primitive_step_unit uut (.*);
  initial begin
    i_clock = 1'h0;
    forever #25 i_clock = ~i_clock;
  end
  task automatic st(input step_op_t op, input logic [31:0] v,
      input logic pr);
    @(posedge i_clock);
    #1;
    i_step = '{1'h1, op, pr};
    i_dividend = ex;
    i_divisor_reg = v;
    u = aq ? ex[31:16] + v[15:0] : ex[31:16] - v[15:0];
    if (!pr && op == OP_SIGN_INIT) begin
      aq = ex[31] ^ v[15];
      ex = {ex[30:0], aq};
    end else if (!pr) begin
      aq = u[15] ^ v[15];
      ex = {u[14:0], ex[15:0], ~aq};
    end
    @(posedge i_clock);
    #1;
    i_step = '0;
    `CHK("wr", !pr, o_dividend_wr)
    `CHK("refused", pr, o_pair_refused)
    `CHK("dividend", ex, o_dividend)
    `CHK("flag", aq, o_quotient_sign_flag)
  endtask : st
  task automatic fw(input flag_wr_t f);
    @(posedge i_clock);
    #1;
    i_flag_wr = f;
    @(posedge i_clock);
    #1;
    i_flag_wr = '0;
  endtask : fw
  task automatic t_signed();
    ex = 32'h0000_008C;
    st(OP_SIGN_INIT, 32'hABCD_0005, 1'h0);
    repeat (15) st(OP_QUOTIENT_STEP, 32'hABCD_0005, 1'h0);
    `CHK("quotient", 16'h000E, o_dividend[15:0])
    `CHK("steps", 5'h0F, o_steps_done)
    `CHK("signed", 1'h1, o_signed_mode)
  endtask : t_signed
  task automatic t_unsigned();
    fw('{1'h1, 1'h0, 1'h0});
    aq = 1'h0;
    ex = 32'h1234_5678;
    `CHK("flag0", 1'h0, o_quotient_sign_flag)
    repeat (16) st(OP_QUOTIENT_STEP, 32'h0000_7FFF, 1'h0);
    st(OP_QUOTIENT_STEP, 32'h0000_7FFF, 1'h1);
    `CHK("steps", 5'h10, o_steps_done)
    `CHK("unsigned", 1'h0, o_signed_mode)
  endtask : t_unsigned
  task automatic t_ovf();
    logic [31:0] dv [2] = '{32'hFFFF_0000, 32'h0000_0008};
    foreach (dv[k]) begin
      ex = 32'h0010_0000;
      st(OP_SIGN_INIT, dv[k], 1'h0);
      `CHK("ov_event", 1'h1, o_overflow_event)
      `CHK("ov_flag", 1'h1, o_accumulator_overflow_flag)
      fw('{1'h0, 1'h0, 1'h1});
      `CHK("ov_clear", 1'h0, o_accumulator_overflow_flag)
    end
  endtask : t_ovf
  task automatic t_short();
    ex = 32'h0000_0100;
    st(OP_SIGN_INIT, 32'h0000_FFF0, 1'h0);
    repeat (3) st(OP_QUOTIENT_STEP, 32'h0000_FFF0, 1'h0);
    `CHK("short", 5'h03, o_steps_done)
  endtask : t_short
  task automatic print_verdict();
    if (n_errors == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    i_rst = 1'h1;
    i_step = '0;
    i_flag_wr = '0;
    i_dividend = '0;
    i_divisor_reg = '0;
    aq = 1'h0;
    repeat (12) @(posedge i_clock);
    #1 i_rst = 1'h0;
    t_signed();
    t_unsigned();
    t_ovf();
    t_short();
    print_verdict();
  end
  initial begin
    #40000;
    n_errors++;
    print_verdict();
  end
endmodule : divide_primitive_step_unit_tb
